// *** common/eagsc_cfg.svh ***
// Purpose: Constants for the address generator and stack checker.
// Assumes: 16-bit data space, byte addressed, word aligned stack.
// Notes: Included by the package, the address calculator and the top design file.
`ifndef EAGSC_CFG_SVH
`define EAGSC_CFG_SVH
`define EAGSC_STACK_FLOOR      16'h0800
`define EAGSC_NEAR_BITS        13
`define EAGSC_FILE_MASK        16'h1FFF
`define EAGSC_WORD_STEP        16'h0002
`define EAGSC_LIMIT_ALIGN_MASK 16'hFFFE
`define EAGSC_PTR_RESET        16'h0800
`define EAGSC_SHORT_LIT_BITS   5
`define EAGSC_BRANCH_LIT_BITS  16
`define EAGSC_DISABLE_LIT_BITS 14
`define EAGSC_IDX_BITS         4
`define EAGSC_DEFAULT_DEFAULT_WORKING_REGISTER     4'h0
`define EAGSC_SP_IDX           4'hF
`endif

// *** common/eagsc_pkg.sv ***
// Purpose: Types for the address generator and stack checker.
// Assumes: Constants come from eagsc_cfg.svh.
// Notes: Mode codes are chosen freely by the decoder interface.
`include "eagsc_cfg.svh"
package eagsc_pkg;
   typedef enum logic [2:0] {
      EAGSC_MODE_FILE   = 3'h0,
      EAGSC_MODE_IND    = 3'h1,
      EAGSC_MODE_POST   = 3'h2,
      EAGSC_MODE_PRE    = 3'h3,
      EAGSC_MODE_INDEX  = 3'h4,
      EAGSC_MODE_LITOFF = 3'h5,
      EAGSC_MODE_PUSH   = 3'h6,
      EAGSC_MODE_POP    = 3'h7
   } eagsc_mode_e;
   typedef enum logic [1:0] {
      EAGSC_PUSH_DATA = 2'h0,
      EAGSC_PUSH_CALL = 2'h1,
      EAGSC_PUSH_EXC  = 2'h2
   } eagsc_push_e;
   typedef enum logic [1:0] {
      EAGSC_ST_IDLE  = 2'b00,
      EAGSC_ST_TRAP  = 2'b01,
      EAGSC_ST_HOLD  = 2'b11
   } eagsc_state_e;
   typedef logic [15:0] eagsc_word_t;
endpackage

// *** hdl/eagsc_ea_calc.sv ***
// Purpose: Combinational effective address and pointer update for one operand.
// Assumes: Pointer and offset values are read from the register file by the caller.
// Notes: Modifier is a signed byte step supplied by the decoder.
`timescale 1ns/1ps
`default_nettype none
`include "eagsc_cfg.svh"
module eagsc_ea_calc (
   // Operand select
   input  wire logic [2:0]  mode,
   input  wire logic [12:0] file_addr,
   input  wire logic        full_space,
   input  wire logic [15:0] file_full_addr,
   // Operand values
   input  wire logic [15:0] ptr_val,
   input  wire logic [15:0] offs_val,
   input  wire logic [15:0] literal,
   input  wire logic [15:0] modifier,
   // Results
   output logic      [15:0] ea,
   output logic      [15:0] ptr_next,
   output logic             ptr_write
);
   always_comb begin
      ea        = ptr_val;
      ptr_next  = ptr_val;
      ptr_write = 1'b0;
      case (eagsc_pkg::eagsc_mode_e'(mode))
         eagsc_pkg::EAGSC_MODE_FILE: begin
            // The data transfer form may reach the whole space.
            ea = full_space ? file_full_addr : {3'h0, file_addr};
         end
         eagsc_pkg::EAGSC_MODE_IND: begin
            ea = ptr_val;
         end
         eagsc_pkg::EAGSC_MODE_POST: begin
            ea        = ptr_val;
            ptr_next  = ptr_val + modifier;
            ptr_write = 1'b1;
         end
         eagsc_pkg::EAGSC_MODE_PRE: begin
            ea        = ptr_val + modifier;
            ptr_next  = ptr_val + modifier;
            ptr_write = 1'b1;
         end
         eagsc_pkg::EAGSC_MODE_INDEX: begin
            ea = ptr_val + offs_val;
         end
         eagsc_pkg::EAGSC_MODE_LITOFF: begin
            ea = ptr_val + literal;
         end
         eagsc_pkg::EAGSC_MODE_PUSH: begin
            ea        = ptr_val;
            ptr_next  = ptr_val + `EAGSC_WORD_STEP;
            ptr_write = 1'b1;
         end
         eagsc_pkg::EAGSC_MODE_POP: begin
            ea        = ptr_val - `EAGSC_WORD_STEP;
            ptr_next  = ptr_val - `EAGSC_WORD_STEP;
            ptr_write = 1'b1;
         end
         default: begin
            ea = ptr_val;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** hdl/eagsc_push_fmt.sv ***
// Purpose: Forms the low and high words of a program counter push.
// Assumes: Program counter is 23 bits wide with bit 0 clear.
// Notes: Data pushes pass the write data through unchanged.
`timescale 1ns/1ps
`default_nettype none
module eagsc_push_fmt (
   // Push kind and sources
   input  wire logic [1:0]  kind,
   input  wire logic [22:0] pc,
   input  wire logic [7:0]  status_low_byte,
   input  wire logic [15:0] data_in,
   input  wire logic        high_half,
   // Word to store
   output logic      [15:0] push_word
);
   always_comb begin
      case (eagsc_pkg::eagsc_push_e'(kind))
         eagsc_pkg::EAGSC_PUSH_CALL: begin
            push_word = high_half ? {9'h000, pc[22:16]} : pc[15:0];
         end
         eagsc_pkg::EAGSC_PUSH_EXC: begin
            push_word = high_half ? {status_low_byte, 1'b0, pc[22:16]} : pc[15:0];
         end
         default: begin
            push_word = data_in;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** hdl/eagsc_top.sv ***
// Purpose: Effective address generation and software stack limit checking.
// Assumes: Decoder presents one operand request per cycle with req high.
// Notes: Holds the stack pointer and its limit; other working registers stay outside.
`timescale 1ns/1ps
`default_nettype none
`include "eagsc_cfg.svh"
// Behaviour
// - Stack pointer holds the next free word; stack grows upward.
// - Push writes then increments; pop decrements then reads.
// - Call push zero-extends the upper program counter bits.
// - Exception push puts the status low byte above the upper counter bits.
// - Limit is not reset; its bit zero always reads and acts as zero.
// - Every address formed with the stack pointer as the pointer register is checked against the limit.
// - Push at the limit is fine; the next push traps.
// - A stack pointer address below the floor raises an underflow stack trap.
// - File direct uses a 13-bit field covering the low 8192 bytes.
// - File results go to the file register or the default working register.
// - Three-operand first operand is a base register; second register, memory or literal.
// - Register indirect address equals the pointer contents.
// - Post-modified uses the pointer, then steps it by a constant.
// - Pre-modified steps the pointer by a signed constant, then uses it.
// - Indexed address is pointer plus base offset register.
// - Literal-offset address is pointer plus instruction literal.
// - Data transfer shares one 4-bit offset register field for both sides.
// - Data transfer file form reaches the whole data space.
// - Branch carries a 16-bit signed literal; interrupt disable a 14-bit literal.
module eagsc_top (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        srst,
   // Operand request from the decoder
   input  wire logic        req,
   input  wire logic [2:0]  mode,
   input  wire logic [3:0]  ptr_sel,
   input  wire logic [3:0]  offs_sel,
   input  wire logic [12:0] file_addr,
   input  wire logic        full_space,
   input  wire logic [15:0] file_full_addr,
   input  wire logic [15:0] ptr_val_ext,
   input  wire logic [15:0] offs_val_ext,
   input  wire logic [15:0] literal,
   input  wire logic [15:0] modifier,
   input  wire logic        dest_is_default_working_register,
   // Three-operand and literal fields
   input  wire logic        op2_kind_lit,
   input  wire logic [4:0]  short_lit,
   input  wire logic [15:0] branch_lit,
   input  wire logic [13:0] disable_lit,
   // Push formatting
   input  wire logic [1:0]  push_kind,
   input  wire logic        push_high,
   input  wire logic [22:0] pc,
   input  wire logic [7:0]  status_low_byte,
   input  wire logic [15:0] push_data,
   // Stack limit write
   input  wire logic        limit_we,
   input  wire logic [15:0] limit_wdata,
   // Memory access
   output logic             mem_valid,
   output logic             mem_write,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   // Pointer write back and result destination
   output logic             ptr_we,
   output logic      [3:0]  ptr_wsel,
   output logic      [15:0] ptr_wdata,
   output logic      [3:0]  result_sel,
   output logic             result_to_file,
   // Literals for the datapath
   output logic      [15:0] op2_literal,
   output logic      [15:0] branch_offset,
   output logic      [15:0] disable_count,
   // State
   output logic      [15:0] stack_pointer_register,
   output logic      [15:0] stack_limit_register,
   output logic             stack_trap
);
   logic [15:0] sp_q;
   logic [15:0] limit_q;
   logic        trap_q;
   logic [15:0] ptr_val;
   logic [15:0] offs_val;
   logic [15:0] ea;
   logic [15:0] ptr_next;
   logic        ptr_write;
   logic [15:0] push_word;
   logic        uses_sp;
   logic        is_push;
   logic        is_pop;
   logic        over_err;
   logic        under_err;
   logic        stack_err;
   logic        addr_q_valid;
   eagsc_pkg::eagsc_state_e state_q;

   function automatic logic is_sp(input logic [3:0] sel);
      is_sp = (sel == `EAGSC_SP_IDX);
   endfunction

   // The stack pointer is kept here so the check sees its live value.
   assign uses_sp  = is_sp(ptr_sel) && (mode != 3'(eagsc_pkg::EAGSC_MODE_FILE));
   assign ptr_val  = uses_sp ? sp_q : ptr_val_ext;
   // One offset field serves source and destination alike.
   assign offs_val = is_sp(offs_sel) ? sp_q : offs_val_ext;
   assign is_push  = (mode == 3'(eagsc_pkg::EAGSC_MODE_PUSH));
   assign is_pop   = (mode == 3'(eagsc_pkg::EAGSC_MODE_POP));

   eagsc_ea_calc u_calc (
      .mode           (mode),
      .file_addr      (file_addr),
      .full_space     (full_space),
      .file_full_addr (file_full_addr),
      .ptr_val        (ptr_val),
      .offs_val       (offs_val),
      .literal        (literal),
      .modifier       (modifier),
      .ea             (ea),
      .ptr_next       (ptr_next),
      .ptr_write      (ptr_write)
   );

   eagsc_push_fmt u_fmt (
      .kind            (push_kind),
      .pc              (pc),
      .status_low_byte (status_low_byte),
      .data_in         (push_data),
      .high_half       (push_high),
      .push_word       (push_word)
   );

   // A push whose address passes the limit traps, so a push at the limit is allowed.
   assign over_err  = req && uses_sp && (ea > limit_q);
   assign under_err = req && uses_sp && (ea < `EAGSC_STACK_FLOOR);
   assign stack_err = over_err || under_err;

   // Stack pointer update, blocked on error so the frame is not corrupted.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         sp_q <= `EAGSC_PTR_RESET;
      end else if (req && uses_sp && ptr_write && !stack_err) begin
         sp_q <= ptr_next & `EAGSC_LIMIT_ALIGN_MASK;
      end
   end

   // Limit has no reset; bit zero is stored as zero.
   // A stack access one cycle after the write already compares against the new value.
   always_ff @(posedge core_clk) begin
      if (limit_we) begin
         limit_q <= limit_wdata & `EAGSC_LIMIT_ALIGN_MASK;
      end
   end

   // Trap state: one pulse, then hold off until the stack error clears.
   // The hold state keeps a decoder that repeats a faulting access from trapping each cycle.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         state_q <= eagsc_pkg::EAGSC_ST_IDLE;
      end else begin
         case (state_q)
            eagsc_pkg::EAGSC_ST_IDLE: begin
               if (stack_err) begin
                  state_q <= eagsc_pkg::EAGSC_ST_TRAP;
               end
            end
            eagsc_pkg::EAGSC_ST_TRAP: begin
               if (stack_err) begin
                  state_q <= eagsc_pkg::EAGSC_ST_HOLD;
               end else begin
                  state_q <= eagsc_pkg::EAGSC_ST_IDLE;
               end
            end
            eagsc_pkg::EAGSC_ST_HOLD: begin
               if (!stack_err) begin
                  state_q <= eagsc_pkg::EAGSC_ST_IDLE;
               end
            end
            default: begin
               state_q <= eagsc_pkg::EAGSC_ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         trap_q <= 1'b0;
      end else begin
         trap_q <= stack_err && (state_q == eagsc_pkg::EAGSC_ST_IDLE);
      end
   end

   // Registered memory request; a stack error suppresses it.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         addr_q_valid <= 1'b0;
         mem_write    <= 1'b0;
      end else begin
         addr_q_valid <= req && !stack_err;
         mem_write    <= req && is_push;
      end
   end

   // Address and write data follow the inputs even when no access is made.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         mem_addr  <= 16'h0000;
         mem_wdata <= 16'h0000;
      end else begin
         mem_addr  <= ea;
         mem_wdata <= push_word;
      end
   end

   // Pointer write back for registers held outside.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ptr_we    <= 1'b0;
         ptr_wsel  <= 4'h0;
         ptr_wdata <= 16'h0000;
      end else begin
         ptr_we    <= req && ptr_write && !uses_sp;
         ptr_wsel  <= ptr_sel;
         ptr_wdata <= ptr_next;
      end
   end

   // Result destination; a multiply picks its register pair outside this block.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         result_sel     <= `EAGSC_DEFAULT_DEFAULT_WORKING_REGISTER;
         result_to_file <= 1'b0;
      end else begin
         result_sel     <= `EAGSC_DEFAULT_DEFAULT_WORKING_REGISTER;
         result_to_file <= !dest_is_default_working_register;
      end
   end

   // Literal fields handed to the datapath.
   always_ff @(posedge core_clk) begin
      if (srst) begin
         op2_literal    <= 16'h0000;
         branch_offset  <= 16'h0000;
         disable_count  <= 16'h0000;
      end else begin
         op2_literal    <= op2_kind_lit ? {11'h000, short_lit} : offs_val;
         branch_offset  <= branch_lit;
         disable_count  <= {2'h0, disable_lit};
      end
   end

   assign mem_valid              = addr_q_valid;
   assign stack_pointer_register = sp_q;
   assign stack_limit_register   = limit_q;
   assign stack_trap             = trap_q;

   // Checks.
   sp_align_a: assert property (@(posedge core_clk) disable iff (srst)
      sp_q[0] == 1'b0) else $error("stack pointer not word aligned");
   push_step_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_push && uses_sp && !stack_err) |=> sp_q == $past(sp_q) + 16'h0002)
      else $error("push did not step pointer");
   pop_addr_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h7 && uses_sp && !stack_err) |=> mem_addr == $past(sp_q) - 16'h0002)
      else $error("pop address wrong");
   limit_lsb_a: assert property (@(posedge core_clk) disable iff (srst)
      $past(limit_we) |-> limit_q == ($past(limit_wdata) & 16'hFFFE))
      else $error("limit write lost or bit zero set");
   over_trap_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_push && uses_sp && sp_q > limit_q && sp_q >= 16'h0800
       && state_q == eagsc_pkg::EAGSC_ST_IDLE) |=> stack_trap)
      else $error("overflow push without trap");
   at_limit_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_push && uses_sp && sp_q == limit_q && sp_q >= 16'h0800) |=> !mem_valid == 1'b0)
      else $error("push at limit refused");
   under_trap_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && uses_sp && ea < 16'h0800) |=> !mem_valid) else $error("underflow not suppressed");
   trap_pulse_a: assert property (@(posedge core_clk) disable iff (srst)
      stack_trap |=> !stack_trap) else $error("trap longer than one cycle");
   file_addr_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h0 && !full_space) |=> mem_addr[15:13] == 3'h0)
      else $error("file address outside near space");
   call_msb_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_push && push_kind == 2'h1 && push_high) |=> mem_wdata[15] == 1'b0)
      else $error("call push top bit set");
   exc_srl_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_push && push_kind == 2'h2 && push_high)
      |=> mem_wdata[15:8] == $past(status_low_byte)) else $error("exception push lost status");

   // Addressing modes through pointers held outside.
   ind_addr_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h1 && !uses_sp)
      |=> mem_addr == $past(ptr_val_ext))
      else $error("indirect address wrong");
   post_step_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h2 && !uses_sp)
      |=> mem_addr == $past(ptr_val_ext)
          && ptr_wdata == $past(ptr_val_ext) + $past(modifier))
      else $error("post-modified access wrong");
   pre_step_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h3 && !uses_sp)
      |=> mem_addr == $past(ptr_val_ext) + $past(modifier)
          && ptr_wdata == mem_addr)
      else $error("pre-modified access wrong");
   index_addr_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h4 && !uses_sp && !is_sp(offs_sel))
      |=> mem_addr == $past(ptr_val_ext) + $past(offs_val_ext))
      else $error("indexed address wrong");
   litoff_addr_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && mode == 3'h5 && !uses_sp)
      |=> mem_addr == $past(ptr_val_ext) + $past(literal))
      else $error("literal offset address wrong");

   // Stack bounds, traps and fields passed through.
   pop_step_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && is_pop && uses_sp && !stack_err)
      |=> sp_q == $past(sp_q) - 16'h0002)
      else $error("pop did not step pointer");
   over_block_a: assert property (@(posedge core_clk) disable iff (srst)
      (req && uses_sp && ea > limit_q)
      |=> !mem_valid && sp_q == $past(sp_q))
      else $error("access past limit not blocked");
   err_hold_a: assert property (@(posedge core_clk) disable iff (srst)
      stack_err |=> !mem_valid && sp_q == $past(sp_q))
      else $error("stack error let access through");
   sp_private_a: assert property (@(posedge core_clk) disable iff (srst)
      ptr_we |-> ptr_wsel != `EAGSC_SP_IDX)
      else $error("stack pointer written back outside");
   lit_pass_a: assert property (@(posedge core_clk) disable iff (srst)
      !srst |=> disable_count == {2'h0, $past(disable_lit)}
          && branch_offset == $past(branch_lit))
      else $error("literal field not passed");
   dest_sel_a: assert property (@(posedge core_clk) disable iff (srst)
      !srst |=> result_to_file == !$past(dest_is_default_working_register) && result_sel == `EAGSC_DEFAULT_DEFAULT_WORKING_REGISTER)
      else $error("result destination wrong");
   op2_lit_a: assert property (@(posedge core_clk) disable iff (srst)
      (!srst && op2_kind_lit) |=> op2_literal == {11'h000, $past(short_lit)})
      else $error("short literal operand wrong");

   push_ok_c: cover property (@(posedge core_clk) disable iff (srst)
      req && is_push && uses_sp && !stack_err);
   over_c: cover property (@(posedge core_clk) disable iff (srst) over_err);
   under_c: cover property (@(posedge core_clk) disable iff (srst) under_err);
   index_c: cover property (@(posedge core_clk) disable iff (srst)
      req && mode == 3'h4);
   trap_c: cover property (@(posedge core_clk) disable iff (srst) stack_trap);
endmodule
`default_nettype wire

// *** testbench/eagsc_mem_model.sv ***
// Purpose: Data memory standing on the far side of the address generator.
// Assumes: One access per cycle, qualified by mem_valid.
// Notes: Reads answer in the access cycle.
`timescale 1ns/1ps
`default_nettype none
module eagsc_mem_model (
   // Clock
   input  wire logic        core_clk,
   // Access from the block
   input  wire logic        mem_valid,
   input  wire logic        mem_write,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   // Answer
   output logic      [15:0] rd_data,
   output var int           n_acc
);
   logic [15:0] store [0:65535];
   int          acc_cnt = 0;
   assign n_acc = acc_cnt;
   always @(posedge core_clk) begin
      if (mem_valid === 1'b1) begin
         acc_cnt <= acc_cnt + 1;
         if (mem_write === 1'b1) store[mem_addr] <= mem_wdata;
      end
   end
   // Outside a read the bus shows the inverted address, so stale data never looks valid.
   assign rd_data = (mem_valid && !mem_write) ? store[mem_addr] : ~mem_addr;
endmodule
`default_nettype wire

// *** testbench/test_ea_gen_stack_check.sv ***
// Purpose: Self-checking bench for the address generator and stack checker.
// Assumes: Every answer from the block appears just after the edge that takes the request.
// Notes: Each request is followed by idle cycles, so traps never come back to back.
`timescale 1ns/1ps
`default_nettype none
module test_ea_gen_stack_check;
   logic        core_clk = 0, srst = 1, req = 0, full_space = 0, dest_is_default_working_register = 0;
   logic        op2_kind_lit = 0, push_high = 0, limit_we = 0;
   logic [2:0]  mode = 3'h0;
   logic [3:0]  ptr_sel = 4'h0, offs_sel = 4'h0;
   logic [12:0] file_addr = 13'h0000;
   logic [15:0] file_full_addr = 16'h0000, ptr_val_ext = 16'h0000, offs_val_ext = 16'h0000;
   logic [15:0] literal = 16'h0000, modifier = 16'h0000, branch_lit = 16'h0000;
   logic [15:0] push_data = 16'h0000, limit_wdata = 16'h0000;
   logic [4:0]  short_lit = 5'h00;
   logic [13:0] disable_lit = 14'h0000;
   logic [1:0]  push_kind = 2'h0;
   logic [22:0] pc = 23'h00_0000;
   logic [7:0]  status_low_byte = 8'h00;
   logic        mem_valid, mem_write, ptr_we, result_to_file, stack_trap;
   logic [3:0]  ptr_wsel, result_sel;
   logic [15:0] mem_addr, mem_wdata, ptr_wdata, op2_literal, branch_offset, disable_count;
   logic [15:0] stack_pointer_register, stack_limit_register, rd_data;
   int          n_acc, mismatches = 0, n_compared = 0;

   eagsc_top u_eagsc_top (.core_clk, .srst, .req, .mode, .ptr_sel, .offs_sel, .file_addr,
      .full_space, .file_full_addr, .ptr_val_ext, .offs_val_ext, .literal, .modifier,
      .dest_is_default_working_register, .op2_kind_lit, .short_lit, .branch_lit, .disable_lit, .push_kind,
      .push_high, .pc, .status_low_byte, .push_data, .limit_we, .limit_wdata, .mem_valid,
      .mem_write, .mem_addr, .mem_wdata, .ptr_we, .ptr_wsel, .ptr_wdata, .result_sel,
      .result_to_file, .op2_literal, .branch_offset, .disable_count,
      .stack_pointer_register, .stack_limit_register, .stack_trap);
   eagsc_mem_model u_eagsc_mem_model (.core_clk, .mem_valid, .mem_write, .mem_addr,
      .mem_wdata, .rd_data, .n_acc);

   initial forever #2 core_clk = ~core_clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Called at a rising edge; returns just after the edge that produced the answer.
   task automatic op(input logic [2:0] m, input logic [3:0] ps);
      req <= 1'b1;
      mode <= m;
      ptr_sel <= ps;
      @(posedge core_clk);
      req <= 1'b0;
      #1;
   endtask
   task automatic t_file;
      @(posedge core_clk);
      file_addr <= 13'h1FFF;
      dest_is_default_working_register <= 1'b1;
      op(eagsc_pkg::EAGSC_MODE_FILE, 4'h0);
      chk(mem_addr, 16'h1FFF);
      chk1(result_to_file, 1'b0);
      chk({12'h000, result_sel}, 16'h0000);
      @(posedge core_clk);
      full_space <= 1'b1;
      file_full_addr <= 16'hABCD;
      dest_is_default_working_register <= 1'b0;
      op(eagsc_pkg::EAGSC_MODE_FILE, 4'h0);
      chk(mem_addr, 16'hABCD);
      chk1(result_to_file, 1'b1);
      @(posedge core_clk);
      full_space <= 1'b0;
   endtask
   task automatic ind(input logic [2:0] m, input logic [15:0] md, input logic [15:0] ea,
                      input logic we, input logic [15:0] nx);
      @(posedge core_clk);
      modifier <= md;
      op(m, 4'h3);
      chk1(mem_valid, 1'b1);
      chk(mem_addr, ea);
      chk1(ptr_we, we);
      if (we) begin
         chk(ptr_wdata, nx);
         chk({12'h000, ptr_wsel}, 16'h0003);
      end
   endtask
   task automatic t_ind;
      ptr_val_ext <= 16'h1000;
      offs_val_ext <= 16'h0010;
      offs_sel <= 4'h5;
      literal <= 16'h0020;
      ind(eagsc_pkg::EAGSC_MODE_IND, 16'h0002, 16'h1000, 1'b0, 16'h0000);
      ind(eagsc_pkg::EAGSC_MODE_POST, 16'h0002, 16'h1000, 1'b1, 16'h1002);
      ind(eagsc_pkg::EAGSC_MODE_PRE, 16'hFFFE, 16'h0FFE, 1'b1, 16'h0FFE);
      ind(eagsc_pkg::EAGSC_MODE_INDEX, 16'h0002, 16'h1010, 1'b0, 16'h0000);
      ind(eagsc_pkg::EAGSC_MODE_LITOFF, 16'h0002, 16'h1020, 1'b0, 16'h0000);
   endtask
   task automatic stk(input logic [2:0] m, input logic [15:0] d, input logic [15:0] w,
                      input logic ok, input logic [15:0] a, input logic [15:0] sp);
      int n0;
      n0 = n_acc;
      @(posedge core_clk);
      push_data <= d;
      op(m, 4'hF);
      chk1(mem_valid, ok);
      chk1(stack_trap, !ok);
      if (ok) chk(mem_addr, a);
      if (ok) chk1(mem_write, m == eagsc_pkg::EAGSC_MODE_PUSH);
      if (ok && m == eagsc_pkg::EAGSC_MODE_PUSH) chk(mem_wdata, w);
      if (ok && m == eagsc_pkg::EAGSC_MODE_POP) chk(rd_data, w);
      chk(stack_pointer_register, sp);
      @(posedge core_clk);
      #1;
      chk1(stack_trap, 1'b0);
      chk1(n_acc == n0 + int'(ok), 1'b1);
      @(posedge core_clk);
   endtask
   task automatic set_limit(input logic [15:0] v, input logic [15:0] rd);
      @(posedge core_clk);
      limit_we <= 1'b1;
      limit_wdata <= v;
      @(posedge core_clk);
      limit_we <= 1'b0;
      #1;
      chk(stack_limit_register, rd);
      // A spare cycle before any stack access through the pointer.
      @(posedge core_clk);
   endtask
   task automatic t_stack;
      set_limit(16'h0803, 16'h0802);
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'hBEEF, 16'hBEEF, 1'b1, 16'h0800, 16'h0802);
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h1234, 16'h1234, 1'b1, 16'h0802, 16'h0804);
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h5555, 16'h5555, 1'b0, 16'h0000, 16'h0804);
      stk(eagsc_pkg::EAGSC_MODE_IND, 16'h0000, 16'h0000, 1'b0, 16'h0000, 16'h0804);
      stk(eagsc_pkg::EAGSC_MODE_POP, 16'h0000, 16'h1234, 1'b1, 16'h0802, 16'h0802);
      stk(eagsc_pkg::EAGSC_MODE_POP, 16'h0000, 16'hBEEF, 1'b1, 16'h0800, 16'h0800);
      stk(eagsc_pkg::EAGSC_MODE_POP, 16'h0000, 16'h0000, 1'b0, 16'h0000, 16'h0800);
   endtask
   task automatic t_pc;
      set_limit(16'h2000, 16'h2000);
      push_kind <= eagsc_pkg::EAGSC_PUSH_CALL;
      pc <= 23'h7F_ABCE;
      status_low_byte <= 8'hA5;
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h0000, 16'hABCE, 1'b1, 16'h0800, 16'h0802);
      push_high <= 1'b1;
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h0000, 16'h007F, 1'b1, 16'h0802, 16'h0804);
      push_high <= 1'b0;
      push_kind <= eagsc_pkg::EAGSC_PUSH_EXC;
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h0000, 16'hABCE, 1'b1, 16'h0804, 16'h0806);
      push_high <= 1'b1;
      stk(eagsc_pkg::EAGSC_MODE_PUSH, 16'h0000, 16'hA57F, 1'b1, 16'h0806, 16'h0808);
      push_high <= 1'b0;
      push_kind <= eagsc_pkg::EAGSC_PUSH_DATA;
   endtask
   task automatic t_lit;
      @(posedge core_clk);
      op2_kind_lit <= 1'b1;
      short_lit <= 5'h1F;
      branch_lit <= 16'h8001;
      disable_lit <= 14'h3FFF;
      op(eagsc_pkg::EAGSC_MODE_FILE, 4'h0);
      chk(op2_literal, 16'h001F);
      chk(branch_offset, 16'h8001);
      chk(disable_count, 16'h3FFF);
   endtask

   initial begin
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      chk(stack_pointer_register, 16'h0800);
      chk1(mem_valid, 1'b0);
      chk1(stack_trap, 1'b0);
      t_file;
      t_ind;
      t_stack;
      t_pc;
      t_lit;
      final_report;
   end
   // A hang counts against the run and still ends in the verdict.
   initial begin
      repeat (2000) @(posedge core_clk);
      mismatches++;
      final_report;
   end
endmodule
`default_nettype wire
